// ---- test/sdr_host.sv ----
// Host controller model acting as SPI master for the readout block.
// Assumes the device samples SDI on rising SPI_CLK and moves SDO after falling, LSB first.
`timescale 1ns/1ns
module sdr_host (
    // SPI pins
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic spi_sdo,
    // Last received frame
    output logic [15:0] rsp,
    output logic rsp_stb
);
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
        rsp = 16'h0000;
        rsp_stb = 1'b0;
    end
    // Clock stands low outside frames; SDI drops to its pull-down level after release
    task automatic xfer(input logic [15:0] cmd);
        integer i;
        spi_cs_n = 1'b0;
        #250;
        for (i = 0; i < 16; i++) begin
            spi_sdi = cmd[i];
            #62 spi_clk = 1'b1;
            rsp[i] = spi_sdo;
            #63 spi_clk = 1'b0;
        end
        #250 spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
        rsp_stb = 1'b1;
        #100 rsp_stb = 1'b0;
        #200;
    endtask
endmodule // sdr_host

// ---- test/sdr_readout_bench.sv ----
// Self-checking bench for the readout block with a host SPI master model.
// Assumes the mode machine and monitors are stood in for by bench signals.
`timescale 1ns/1ns
module sdr_readout_bench import sdr_pkg::*;;
    logic clk, reset, sck, cs_n, sdi, sdo, sdo_oe, rsp_stb, by_fail, rr_set, lh_set, wd_fail, dev, stb, trig, rreq;
    logic [2:0] mode_cur, lh_code, hw, mreq, last_sel;
    logic [1:0] rr_code, comm;
    logic [9:0] wk_ev, wk_st;
    logic [10:0] per;
    logic [8:0] cfg, wdog;
    logic [15:0] rsp, prev;
    logic [15:0] exp_q[$];
    int miscompares, comparisons, trig_cnt, stb_cnt, rst_cnt, seed, k, k2, oe_miss;
    sdr_readout sdr_readout_i (.CLK_SYS(clk), .RESET(reset), .SPI_CLK(sck), .SPI_CS_N(cs_n), .SPI_SDI(sdi),
        .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .MODE_CUR(mode_cur), .RESTART_BY_FAIL(by_fail), .MODE_REQ(mreq),
        .MODE_REQ_STB(stb), .RESTART_SET(rr_set), .RESTART_CODE(rr_code), .LIMP_SET(lh_set),
        .LIMP_CODE(lh_code), .HW_CFG_PIN(hw), .WAKE_EVENT(wk_ev), .WAKE_STATE(wk_st), .WD_FAIL(wd_fail),
        .WD_PERIOD_MS(per), .WD_TRIGGER(trig), .WD_RESET_REQ(rreq), .SW_DEV_MODE(dev), .CFG_OUT(cfg),
        .COMM_OUT(comm), .WDOG_OUT(wdog));
    sdr_host sdr_host_i (.spi_clk(sck), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .rsp(rsp),
        .rsp_stb(rsp_stb));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        trig_cnt += (trig === 1'b1);
        stb_cnt += (stb === 1'b1);
        rst_cnt += (rreq === 1'b1);
    end
    // Every rising link edge inside a frame must find the output driven
    always @(posedge sck) begin
        oe_miss += (sdo_oe !== 1'b1);
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        check("notes left", 16'(exp_q.size()), 16'h0000);
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Each received frame is compared with the oldest note; mask is the second note of the pair
    always @(posedge rsp_stb) begin
        logic [15:0] exp_v;
        if (exp_q.size() >= 2) begin
            exp_v = exp_q.pop_front();
            check("sdo frame", rsp & exp_q.pop_front(), exp_v);
        end else begin
            check("sdo note", 16'(exp_q.size()), 16'h0002);
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Mode field of the answer is masked off unless the caller asks for the whole frame
    task automatic frame(input logic [2:0] md, input logic [2:0] sel, input logic [9:0] dat,
                         input logic [15:0] exp, input logic [15:0] msk);
        // Header select goes out before the command's select is in, so it is the previous one
        if (md == MODE_READ_ONLY) begin
            exp[SEL_LSB +: 3] = last_sel;
        end
        exp_q.push_back(exp & msk);
        exp_q.push_back(msk);
        sdr_host_i.xfer({dat, sel, md});
        last_sel = sel;
        tick(2);
        check("sdo oe idle", {15'h0000, sdo_oe}, 16'h0000);
    endtask
    function automatic logic [15:0] diag(input logic [1:0] r, input logic [2:0] l, input logic [2:0] h);
        return {2'b00, h, l, r, SEL_DIAG, 3'h0};
    endfunction
    task automatic first_frame(input logic [2:0] pm, input logic f, input logic [2:0] sel, input logic [9:0] d);
        by_fail = f;
        mode_cur = pm;
        tick(4);
        mode_cur = MODE_NORMAL;
        tick(4);
        k = stb_cnt;
        frame(MODE_NORMAL, SEL_DIAG, 10'h3FF, {d, sel, pm}, 16'hFFFF);
        check("cfg kept", {7'h00, cfg}, {7'h00, CFG_RESET});
        check("first req", 16'(stb_cnt - k), 16'h0001);
    endtask
    task automatic pulse(input int which);
        tick(1);
        {rr_set, lh_set, wd_fail} = 3'b100 >> which;
        tick(1);
        {rr_set, lh_set, wd_fail} = 3'b000;
        tick(3);
    endtask
    initial begin
        logic [4:0] c;
        logic [7:0] d8;
        seed = 16;
        {by_fail, rr_set, lh_set, wd_fail, rr_code, lh_code, hw, wk_ev} = '0;
        mode_cur = MODE_INIT;
        wk_st = 10'h100;
        reset = 1'b1;
        tick(20);
        reset = 1'b0;
        tick(4);
        check("period", {5'h00, per}, 16'h0100);
        mode_cur = MODE_NORMAL;
        tick(4);
        frame(MODE_NORMAL, SEL_COMM, 10'h003, {1'b0, CFG_RESET, SEL_CFG, MODE_INIT}, 16'hFFFF);
        check("comm", {14'h0000, comm}, 16'h0003);
        check("mode req", {10'h000, mreq, stb_cnt[2:0]}, {10'h000, MODE_NORMAL, 3'h1});
        k = trig_cnt;
        frame(MODE_NORMAL, SEL_WDOG, 10'h0E0, {10'h003, SEL_COMM, 3'h0}, 16'hFFF8);
        check("bad parity", {wdog, 7'(trig_cnt - k)}, {WDOG_RESET, 7'h00});
        prev = {7'h00, WDOG_RESET};
        for (int i = 0; i < 6; i++) begin
            // End points first: 0, 15, 31, 16
            c = (i < 4) ? {i[1], {4{i[0] ^ i[1]}}} : 5'($random(seed));
            d8 = {3'b111, c};
            frame(MODE_NORMAL, SEL_WDOG, {1'b0, ^d8, d8}, {prev[9:0], SEL_WDOG, 3'h0}, 16'hFFF8);
            prev = {7'h00, ^d8, d8};
            check("wdog", {7'h00, wdog}, prev);
            check("period", {5'h00, per}, (c < 5'h10) ? ({11'h000, c} + 16'h0001) * 16'h0010
                : {11'h000, c} * 16'h0030 - 16'h01D0);
        end
        for (int i = 1; i < 5; i++) begin
            rr_code = 2'(i);
            if (i < 4) pulse(0);
            k = trig_cnt;
            k2 = stb_cnt;
            frame(MODE_READ_ONLY, SEL_DIAG, 10'h000, diag(2'(i & 3), 3'h0, 3'h0), 16'hFFF8);
            check("ro trigger", {8'(stb_cnt - k2), 8'(trig_cnt - k)}, 16'h0001);
        end
        for (int i = 0; i < 8; i++) begin
            lh_code = 3'(i);
            pulse(1);
            frame(MODE_READ_ONLY, SEL_DIAG, 10'h000, diag(2'h0, 3'(i), 3'h0), 16'hFFF8);
        end
        frame(MODE_NORMAL, SEL_CFG, {1'b0, CFG_RESET}, diag(2'h0, 3'h7, 3'h0), 16'hFFF8);
        frame(MODE_READ_ONLY, SEL_DIAG, 10'h000, diag(2'h0, 3'h0, 3'h0), 16'hFFF8);
        wk_ev = 10'h3FF;
        tick(1);
        wk_ev = 10'h000;
        frame(MODE_READ_ONLY, SEL_WAKE, 10'h000, {10'h1FF, SEL_WAKE, 3'h0}, 16'hFFF8);
        frame(MODE_READ_ONLY, SEL_WAKE, 10'h000, {10'h100, SEL_WAKE, 3'h0}, 16'hFFF8);
        hw = 3'h4;
        tick(4);
        k = rst_cnt;
        pulse(2);
        check("dev mode", {15'h0000, dev}, 16'h0001);
        check("dev reset", 16'(rst_cnt - k), 16'h0000);
        frame(MODE_READ_ONLY, SEL_DIAG, 10'h000, diag(2'h0, 3'h0, 3'h4), 16'hFFF8);
        hw = 3'h3;
        tick(4);
        pulse(2);
        check("fail reset", 16'(rst_cnt - k), 16'h0001);
        hw = 3'h0;
        rr_code = 2'h2;
        pulse(0);
        first_frame(MODE_SLEEP, 1'b0, SEL_WAKE, 10'h100);
        frame(MODE_READ_ONLY, SEL_DIAG, 10'h000, diag(2'h0, 3'h0, 3'h0), 16'hFFF8);
        lh_code = 3'h5;
        pulse(1);
        first_frame(MODE_FAILSAFE, 1'b0, SEL_DIAG, 10'h014);
        first_frame(MODE_RESTART, 1'b1, SEL_DIAG, 10'h014);
        first_frame(MODE_RESTART, 1'b0, SEL_CFG, {1'b0, CFG_RESET});
        check("oe in frame", 16'(oe_miss), 16'h0000);
        wrap_up();
    end
    // Bounded run: a hang counts as a mismatch
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
endmodule // sdr_readout_bench

// ---- verilog/sdr_pkg.sv ----
// Constants for the SPI status and diagnostic readout block.
// Assumes 16-bit frames sent LSB first, with mode bits first, then the select, then the data.
package sdr_pkg;
    // Frame layout
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] DATA_START = 5'h06;
    localparam int MS_LSB = 0;
    localparam int SEL_LSB = 3;
    localparam int DATA_LSB = 6;
    localparam int DATA_W = 10;
    // Mode codes in the mode select field
    localparam logic [2:0] MODE_INIT = 3'h0;
    localparam logic [2:0] MODE_NORMAL = 3'h1;
    localparam logic [2:0] MODE_SLEEP = 3'h2;
    localparam logic [2:0] MODE_RESTART = 3'h3;
    localparam logic [2:0] MODE_FAILSAFE = 3'h4;
    localparam logic [2:0] MODE_READ_ONLY = 3'h7;
    // Configuration select codes
    localparam logic [2:0] SEL_WAKE = 3'h0;
    localparam logic [2:0] SEL_CFG = 3'h4;
    localparam logic [2:0] SEL_COMM = 3'h5;
    localparam logic [2:0] SEL_WDOG = 3'h6;
    localparam logic [2:0] SEL_DIAG = 3'h7;
    // Configuration register: RT[1:0], delay, vcc3, wake pin, vcc2, limp, cyclic, wdog_fail_to_limp_count
    localparam logic [8:0] CFG_RESET = 9'h115;
    localparam int CFG_LIMP_BIT = 6;
    localparam logic [1:0] COMM_RESET = 2'h0;
    // Watchdog register: period[4:0], timeout, fixed one, enable, wdog_write_parity
    localparam logic [8:0] WDOG_RESET = 9'h1EF;
    localparam int WDOG_PAR_BIT = 8;
    localparam int WDOG_PER_W = 5;
    // Watchdog period decode, in ms
    localparam logic [4:0] WD_SPLIT = 5'h10;
    localparam logic [10:0] WD_SHORT_MS = 11'h010;
    localparam logic [10:0] WD_LONG_MUL = 11'h030;
    localparam logic [10:0] WD_LONG_SUB = 11'h1D0;
    // Diagnostic codes
    localparam logic [1:0] RR_NONE = 2'h0;
    localparam logic [2:0] LIMP_NONE = 3'h0;
    localparam int HW_DEV_BIT = 2;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } sdr_state_t;
endpackage

// ---- verilog/sdr_readout.sv ----
// SPI status and diagnostic readout of a system basis chip, the device end.
// Assumes the mode machine, wake and supply monitors sit outside on CLK_SYS; SPI pins are asynchronous.
`timescale 1ns/1ns
module sdr_readout import sdr_pkg::*; #(
    parameter logic [DATA_W-1:0] WAKE_LIVE_MASK = 10'h300
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // SPI pins
    input wire logic SPI_CLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    output logic SPI_SDO,
    output logic SPI_SDO_OE,
    // Mode machine
    input wire logic [2:0] MODE_CUR,
    input wire logic RESTART_BY_FAIL,
    output logic [2:0] MODE_REQ,
    output logic MODE_REQ_STB,
    // Diagnostic events
    input wire logic RESTART_SET,
    input wire logic [1:0] RESTART_CODE,
    input wire logic LIMP_SET,
    input wire logic [2:0] LIMP_CODE,
    input wire logic [2:0] HW_CFG_PIN,
    input wire logic [DATA_W-1:0] WAKE_EVENT,
    input wire logic [DATA_W-1:0] WAKE_STATE,
    // Watchdog
    input wire logic WD_FAIL,
    output logic [10:0] WD_PERIOD_MS,
    output logic WD_TRIGGER,
    output logic WD_RESET_REQ,
    output logic SW_DEV_MODE,
    // Settings
    output logic [8:0] CFG_OUT,
    output logic [1:0] COMM_OUT,
    output logic [8:0] WDOG_OUT
);
    typedef struct packed {
        sdr_state_t st;
        logic sclk_d;
        logic [4:0] bit_cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic sdo;
        logic sdo_oe;
        logic [2:0] prev_sel;
        logic first_pend;
        logic [2:0] first_mode;
        logic [2:0] first_sel;
        logic [2:0] mode_d;
        logic [8:0] cfg;
        logic [1:0] comm;
        logic [8:0] wdog;
        logic [1:0] restart_reason;
        logic [2:0] limp_cause;
        logic [2:0] hw_cfg;
        logic [DATA_W-1:0] wake;
        logic [10:0] wd_ms;
        logic wd_trig;
        logic wd_rst;
        logic [2:0] mreq;
        logic mreq_stb;
    } sdr_reg_t;

    sdr_reg_t r_reg;
    sdr_reg_t r_next;
    logic [5:0] sync_q;
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic [2:0] hw_s;
    logic commit;
    logic ro_commit;
    logic [2:0] rx_mode;
    logic [2:0] rx_sel;
    logic [DATA_W-1:0] rx_data;
    logic wdog_par_ok;
    logic [2:0] out_mode;
    logic [2:0] out_sel;

    sdr_sync #(.W(6), .RST_VAL(6'h02)) u_sync (
        .clk(CLK_SYS),
        .reset(RESET),
        .d({HW_CFG_PIN, SPI_SDI, SPI_CS_N, SPI_CLK}),
        .q(sync_q)
    );
    assign sclk_s = sync_q[0];
    assign cs_n_s = sync_q[1];
    assign sdi_s = sync_q[2];
    assign hw_s = sync_q[5:3];

    function automatic logic [10:0] wd_period(input logic [4:0] code);
        logic [10:0] c;
        c = {6'h00, code};
        if (code < WD_SPLIT) begin
            wd_period = 11'((c + 11'h001) * WD_SHORT_MS);
        end else begin
            wd_period = 11'(c * WD_LONG_MUL - WD_LONG_SUB);
        end
    endfunction

    // Output data for a select code; encodings exist only on this path
    function automatic logic [DATA_W-1:0] sel_data(input logic [2:0] sel, input sdr_reg_t s,
                                                     input logic [DATA_W-1:0] live);
        case (sel)
            SEL_WAKE: sel_data = (s.wake & ~WAKE_LIVE_MASK) | (live & WAKE_LIVE_MASK);
            SEL_CFG: sel_data = {1'b0, s.cfg};
            SEL_COMM: sel_data = {8'h00, s.comm};
            SEL_WDOG: sel_data = {1'b0, s.wdog};
            SEL_DIAG: sel_data = {2'h0, s.hw_cfg, s.limp_cause, s.restart_reason};
            default: sel_data = '0;
        endcase
    endfunction

    assign rx_mode = r_reg.rx[MS_LSB +: 3];
    assign rx_sel = r_reg.rx[SEL_LSB +: 3];
    assign rx_data = r_reg.rx[DATA_LSB +: DATA_W];
    assign commit = (r_reg.st == ST_SHIFT) && cs_n_s && (r_reg.bit_cnt == FRAME_BITS);
    assign ro_commit = commit && (rx_mode == MODE_READ_ONLY);
    // Parity covers every watchdog bit below the parity bit
    assign wdog_par_ok = (^rx_data[WDOG_PAR_BIT-1:0]) == rx_data[WDOG_PAR_BIT];
    // A pending first frame overrides the previous request
    assign out_mode = r_reg.first_pend ? r_reg.first_mode : r_reg.mode_d;
    assign out_sel = r_reg.first_pend ? r_reg.first_sel : r_reg.prev_sel;

    always_comb begin
        r_next = r_reg;
        r_next.sclk_d = sclk_s;
        r_next.mode_d = MODE_CUR;
        r_next.hw_cfg = hw_s;
        r_next.wd_trig = 1'b0;
        r_next.wd_rst = 1'b0;
        r_next.mreq_stb = 1'b0;
        case (r_reg.st)
            ST_IDLE: begin
                r_next.sdo_oe = 1'b0;
                if (!cs_n_s) begin
                    // Frame starts: preload output, first bit driven at once
                    r_next.st = ST_SHIFT;
                    r_next.bit_cnt = '0;
                    r_next.tx = {sel_data(out_sel, r_reg, WAKE_STATE), out_sel, out_mode};
                    r_next.sdo = out_mode[0];
                    r_next.sdo_oe = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (cs_n_s) begin
                    r_next.st = ST_IDLE;
                    r_next.sdo_oe = 1'b0;
                end else if (sclk_s && !r_reg.sclk_d && r_reg.bit_cnt < FRAME_BITS) begin
                    r_next.rx[r_reg.bit_cnt[3:0]] = sdi_s;
                    r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                    // Mode and select are known before the data bits leave
                    if (r_next.bit_cnt == DATA_START && r_next.rx[MS_LSB +: 3] == MODE_READ_ONLY) begin
                        r_next.tx[DATA_LSB +: DATA_W] = sel_data(r_next.rx[SEL_LSB +: 3], r_reg,
                                                                 WAKE_STATE);
                    end
                end else if (!sclk_s && r_reg.sclk_d && r_reg.bit_cnt < FRAME_BITS) begin
                    r_next.sdo = r_reg.tx[r_reg.bit_cnt[3:0]];
                end
            end
            default: begin
                r_next.st = ST_IDLE;
                r_next.sdo_oe = 1'b0;
            end
        endcase
        // Clears come first so a same-cycle event still lands
        if (commit) begin
            r_next.first_pend = 1'b0;
            r_next.prev_sel = rx_sel;
            if (ro_commit) begin
                // No write and no mode change on read-only
                r_next.wd_trig = 1'b1;
                if (rx_sel == SEL_WAKE) begin
                    r_next.wake = r_reg.wake & WAKE_LIVE_MASK;
                end
                if (rx_sel == SEL_DIAG) begin
                    r_next.restart_reason = RR_NONE;
                end
            end else begin
                r_next.mreq = rx_mode;
                r_next.mreq_stb = 1'b1;
                case (rx_sel)
                    SEL_CFG: begin
                        r_next.cfg = rx_data[8:0];
                        if (!rx_data[CFG_LIMP_BIT]) begin
                            r_next.limp_cause = LIMP_NONE;
                        end
                    end
                    SEL_COMM: r_next.comm = rx_data[1:0];
                    SEL_WDOG: begin
                        if (wdog_par_ok) begin
                            r_next.wdog = rx_data[8:0];
                            r_next.wd_trig = 1'b1;
                        end
                    end
                    // Diagnosis select is not writable
                    default: r_next.wdog = r_next.wdog;
                endcase
            end
        end
        if ((r_reg.mode_d == MODE_SLEEP || r_reg.mode_d == MODE_FAILSAFE) && MODE_CUR != r_reg.mode_d) begin
            r_next.restart_reason = RR_NONE;
        end
        if (MODE_CUR == MODE_NORMAL && r_reg.mode_d != MODE_NORMAL) begin
            r_next.first_pend = 1'b1;
            r_next.first_mode = r_reg.mode_d;
            case (r_reg.mode_d)
                MODE_SLEEP: r_next.first_sel = SEL_WAKE;
                MODE_FAILSAFE: r_next.first_sel = SEL_DIAG;
                MODE_RESTART: r_next.first_sel = RESTART_BY_FAIL ? SEL_DIAG : SEL_CFG;
                default: r_next.first_sel = SEL_CFG;
            endcase
        end
        if (RESTART_SET) begin
            r_next.restart_reason = RESTART_CODE;
        end
        if (LIMP_SET) begin
            r_next.limp_cause = LIMP_CODE;
        end
        r_next.wake = r_next.wake | (WAKE_EVENT & ~WAKE_LIVE_MASK);
        // Dev mode suppresses the watchdog reset request
        r_next.wd_rst = WD_FAIL && !r_reg.hw_cfg[HW_DEV_BIT];
        // One cycle behind the setting to keep the multiplier off the output
        r_next.wd_ms = wd_period(r_reg.wdog[WDOG_PER_W-1:0]);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            r_reg <= '{st: ST_IDLE, sclk_d: 1'b0, bit_cnt: 5'h00, rx: 16'h0000, tx: 16'h0000,
                       sdo: 1'b0, sdo_oe: 1'b0, prev_sel: SEL_CFG, first_pend: 1'b0,
                       first_mode: MODE_INIT, first_sel: SEL_CFG, mode_d: MODE_INIT, cfg: CFG_RESET,
                       comm: COMM_RESET, wdog: WDOG_RESET, restart_reason: RR_NONE,
                       limp_cause: LIMP_NONE, hw_cfg: 3'h0, wake: 10'h000,
                       wd_ms: wd_period(WDOG_RESET[WDOG_PER_W-1:0]),
                       wd_trig: 1'b0, wd_rst: 1'b0, mreq: MODE_INIT, mreq_stb: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign SPI_SDO = r_reg.sdo;
    assign SPI_SDO_OE = r_reg.sdo_oe;
    assign MODE_REQ = r_reg.mreq;
    assign MODE_REQ_STB = r_reg.mreq_stb;
    assign WD_PERIOD_MS = r_reg.wd_ms;
    assign WD_TRIGGER = r_reg.wd_trig;
    assign WD_RESET_REQ = r_reg.wd_rst;
    assign SW_DEV_MODE = r_reg.hw_cfg[HW_DEV_BIT];
    assign CFG_OUT = r_reg.cfg;
    assign COMM_OUT = r_reg.comm;
    assign WDOG_OUT = r_reg.wdog;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence s_ro_frame;
        ro_commit;
    endsequence
    sequence s_leave_rest;
        (r_reg.mode_d == MODE_SLEEP || r_reg.mode_d == MODE_FAILSAFE) && MODE_CUR != r_reg.mode_d;
    endsequence
    sequence s_enter_normal_from(logic [2:0] m);
        MODE_CUR == MODE_NORMAL && r_reg.mode_d == m;
    endsequence
    sequence s_write_frame;
        commit && !ro_commit;
    endsequence

    wd_short_a: assert property ($past(r_reg.wdog[4:0]) < 5'h10 |->
        WD_PERIOD_MS == 11'(({6'h00, $past(r_reg.wdog[4:0])} + 11'h001) * 11'h010))
        else $error("short watchdog period wrong");
    wd_long_a: assert property ($past(r_reg.wdog[4:0]) >= 5'h10 |->
        WD_PERIOD_MS == 11'({6'h00, $past(r_reg.wdog[4:0])} * 11'h030 - 11'h1D0))
        else $error("long watchdog period wrong");
    ro_clear_rr_a: assert property (s_ro_frame ##0 rx_sel == SEL_DIAG && !RESTART_SET |=>
        r_reg.restart_reason == 2'h0)
        else $error("read-only did not clear restart reason");
    leave_clear_rr_a: assert property (s_leave_rest ##0 !RESTART_SET |=> r_reg.restart_reason == 2'h0)
        else $error("restart reason kept after leaving sleep or fail-safe");
    limp_clear_a: assert property (commit && rx_mode != MODE_READ_ONLY && rx_sel == SEL_CFG
        && !rx_data[CFG_LIMP_BIT] && !LIMP_SET |=> r_reg.limp_cause == 3'h0)
        else $error("limp cause not cleared");
    dev_no_reset_a: assert property (WD_FAIL && SW_DEV_MODE |=> !WD_RESET_REQ)
        else $error("reset raised in development mode");
    ro_no_write_a: assert property (s_ro_frame |=> !MODE_REQ_STB && WD_TRIGGER && $stable(CFG_OUT)
        && $stable(WDOG_OUT))
        else $error("read-only changed settings or mode");
    first_sleep_a: assert property (s_enter_normal_from(MODE_SLEEP) |=>
        r_reg.first_pend && r_reg.first_sel == SEL_WAKE && r_reg.first_mode == MODE_SLEEP)
        else $error("first frame after sleep wrong");
    bad_parity_a: assert property (commit && rx_mode != MODE_READ_ONLY && rx_sel == SEL_WDOG
        && !wdog_par_ok |=> $stable(WDOG_OUT) && !WD_TRIGGER)
        else $error("watchdog write with bad parity taken");
    cs_release_a: assert property (r_reg.st == ST_SHIFT && cs_n_s |=> !SPI_SDO_OE ##1 !SPI_SDO_OE)
        else $error("output still driven after chip select release");
    // Loads and clears are guarded one cycle after their cause
    sdo_idle_a: assert property (r_reg.st == ST_IDLE && cs_n_s |=>
        !SPI_SDO_OE)
        else $error("output driven between frames");
    rr_set_a: assert property (RESTART_SET |=>
        r_reg.restart_reason == $past(RESTART_CODE))
        else $error("restart reason not loaded");
    limp_set_a: assert property (LIMP_SET |=>
        r_reg.limp_cause == $past(LIMP_CODE))
        else $error("limp cause not loaded");
    wake_clear_a: assert property (s_ro_frame ##0 rx_sel == SEL_WAKE && !(|WAKE_EVENT) |=>
        (r_reg.wake & ~WAKE_LIVE_MASK) == '0)
        else $error("sticky wake bits kept after read-only");
    write_keep_a: assert property (s_write_frame ##0 !RESTART_SET && MODE_CUR == r_reg.mode_d |=>
        $stable(r_reg.restart_reason))
        else $error("write frame cleared restart reason");
    first_fail_a: assert property (s_enter_normal_from(MODE_FAILSAFE) |=>
        r_reg.first_pend && r_reg.first_sel == SEL_DIAG && r_reg.first_mode == MODE_FAILSAFE)
        else $error("first frame after fail-safe wrong");
    first_restart_a: assert property (s_enter_normal_from(MODE_RESTART) |=>
        r_reg.first_sel == ($past(RESTART_BY_FAIL) ? SEL_DIAG : SEL_CFG))
        else $error("first frame after restart wrong");
    wdog_write_a: assert property (s_write_frame ##0 rx_sel == SEL_WDOG && wdog_par_ok |=>
        WD_TRIGGER && WDOG_OUT == $past(rx_data[8:0]))
        else $error("valid watchdog write not taken");
endmodule // sdr_readout

// ---- verilog/sdr_sync.sv ----
// Two-flop synchroniser for inputs arriving from outside the system clock.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ns
module sdr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // sdr_sync
